// >>> bench/flash_prog_sva.sv
`timescale 1ns/10ps

module flash_prog_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // link wires
  input wire logic sclk,
  input wire logic serial_select_n,
  // device outputs
  input wire logic flash_program_mode_o,
  input wire logic processor_halt_o,
  input wire logic compute_disable_o,
  input wire logic flash_write_o,
  input wire logic flash_ctrl_reset_o,
  input wire logic [15:0] access_addr_o,
  // entry preconditions
  input wire logic emulator_enable_input_i,
  input wire logic phase_flag_a_i,
  input wire logic secure_i,
  input wire logic [3:0] flash_unlock_key_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  //////////////////////////////////////////////////
  // frame start and mode entry steps
  sequence s_lead;
    !sclk [*8];
  endsequence
  sequence s_entry;
    $rose(flash_program_mode_o);
  endsequence

  // link clock parked low outside and at the head of frames
  a_idle_clock: assert property (
    serial_select_n |-> !sclk) else $error("link clock moved idle");
  a_select_lead: assert property (
    $fell(serial_select_n) |-> s_lead) else $error("short frame lead");
  // mode left only by reset, halt and engine follow it
  a_mode_sticky: assert property (
    flash_program_mode_o |=> flash_program_mode_o)
    else $error("mode dropped");
  a_halt_tracks: assert property (
    processor_halt_o == flash_program_mode_o &&
    compute_disable_o == flash_program_mode_o)
    else $error("halt differs from mode");
  a_entry_guard: assert property (
    s_entry |-> $past(emulator_enable_input_i && !phase_flag_a_i &&
    !secure_i && flash_unlock_key_i == 4'h2))
    else $error("entry without preconditions");
  a_entry_ctrl_reset: assert property (
    s_entry |-> $past(flash_ctrl_reset_o) or ##[0:1] flash_ctrl_reset_o)
    else $error("no flash control reset");
  // word commits to even addresses and only in mode
  a_write_even: assert property (
    flash_write_o |-> !access_addr_o[0]) else $error("odd word address");
  a_flash_gated: assert property (
    !flash_program_mode_o |-> !flash_write_o)
    else $error("flash write outside mode");
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/10ps
`include "flash_prog_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end

module tb_top;
  logic clk_i;
  logic resetn_i;
  logic hsel;
  logic hwrite;
  logic hreadyout;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic emu, pre, sec, tpin, fw, fe, fcr, sclr, mode, halt, cdis, mwe;
  logic [3:0] key;
  logic [15:0] aa, fwd, w_data, w_addr, m_wr;
  logic [9:0] bcnt = 10'h0;
  logic [31:0] rx;
  logic [7:0] st, mwd;
  int err_total = 0;
  int checked = 0;
  int n_er = 0;
  int n_cr = 0;
  int n_sc = 0;
  int n_wr = 0;

  flash_prog_if link ();
  flash_prog_host flash_prog_host_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .link(link.host));
  flash_prog_device flash_prog_device_inst (.clk_i(clk_i),
    .resetn_i(resetn_i), .link(link.device),
    .emulator_enable_input_i(emu), .phase_flag_a_i(pre), .secure_i(sec),
    .flash_unlock_key_i(key), .test_pin_i(tpin), .access_addr_o(aa),
    .mem_rdata_i(~aa[7:0]), .mem_we_o(mwe), .mem_wdata_o(mwd),
    .flash_rdata_i(aa[7:0] ^ 8'h3C), .flash_busy_i(bcnt != 10'h0),
    .flash_write_o(fw), .flash_wdata_o(fwd), .flash_erase_o(fe),
    .flash_ctrl_reset_o(fcr), .secure_clear_o(sclr),
    .flash_program_mode_o(mode), .processor_halt_o(halt),
    .compute_disable_o(cdis));
  flash_prog_sva flash_prog_sva_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .sclk(link.sclk), .serial_select_n(link.serial_select_n),
    .flash_program_mode_o(mode), .processor_halt_o(halt),
    .compute_disable_o(cdis), .flash_write_o(fw), .flash_ctrl_reset_o(fcr),
    .access_addr_o(aa), .emulator_enable_input_i(emu),
    .phase_flag_a_i(pre), .secure_i(sec), .flash_unlock_key_i(key));

  //////////////////////////////////////////////////
  // clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // flash model: erase keeps it busy, pulses are counted
  always @(posedge clk_i) begin
    bcnt <= fe ? 10'h258 : bcnt - 10'(bcnt != 10'h0);
    n_er <= n_er + fe;
    n_cr <= n_cr + fcr;
    n_sc <= n_sc + sclr;
    if (mwe) m_wr <= {aa[7:0], mwd};
    if (fw) begin
      n_wr <= n_wr + 1;
      w_data <= fwd;
      w_addr <= aa;
    end
  end

  //////////////////////////////////////////////////
  // verdict and bus helpers
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic stop_if(input logic c);
    if (c) begin
      err_total++;
      conclude();
    end
  endtask

  task automatic rdy(inout int n);
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    stop_if(n >= 40);
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy(n);
    htrans <= 2'h0;
    hwdata <= d;
    rdy(n);
    r = hrdata;
  endtask

  // one link frame: command, address, n data bytes
  task automatic frame(input logic [7:0] c, input logic [15:0] a,
                       input logic [2:0] n, input logic [31:0] tx);
    logic [31:0] r;
    int k;
    ahb(1'b1, `FP_HOST_ADDR, {16'h0, a}, r);
    ahb(1'b1, `FP_HOST_TXDATA, tx, r);
    ahb(1'b1, `FP_HOST_CTRL, {1'b1, 20'h0, n, c}, r);
    k = 0;
    do begin
      ahb(1'b0, `FP_HOST_LINKSTAT, 32'h0, r);
      k++;
    end while (r[8] !== 1'b0 && k < 300);
    stop_if(k >= 300);
    st = r[7:0];
    ahb(1'b0, `FP_HOST_RXDATA, 32'h0, rx);
  endtask

  task automatic poll();
    frame(`FP_CMD_WRITE, 16'h0, 3'h0, 32'h0);
  endtask

  task automatic enter(input logic [7:0] s);
    frame(`FP_CMD_WRITE, `FP_MODE_SELECT_ADDR, 3'h1, {24'h0, s});
    frame(`FP_CMD_WRITE, `FP_MODE_TRIGGER_ADDR, 3'h1, 32'h96);
  endtask

  //////////////////////////////////////////////////
  // scenarios
  task automatic t_select();
    frame(`FP_CMD_WRITE, 16'h0040, 3'h1, 32'h5A);
    `CHK("mem write", 16'h405A, m_wr)
    frame(`FP_CMD_WRITE, `FP_MODE_SELECT_ADDR, 3'h1, 32'hD1);
    frame(`FP_CMD_READ, `FP_MODE_SELECT_ADDR, 3'h1, 32'h0);
    `CHK("select", 8'hD1, rx[7:0])
    frame(`FP_CMD_WRITE, `FP_MODE_TRIGGER_ADDR, 3'h1, 32'h00);
    `CHK("mode", 1'b0, mode)
    frame(`FP_CMD_READ, `FP_MODE_SELECT_ADDR, 3'h1, 32'h0);
    `CHK("select", 8'h00, rx[7:0])
  endtask

  task automatic t_guard();
    for (int i = 0; i < 7; i++) begin
      emu <= i != 0;
      pre <= i == 1;
      sec <= i == 2;
      key <= i == 3 ? 4'h3 : `FP_UNLOCK_KEY;
      enter(i < 4 ? (i == 2 ? 8'h2E : 8'hD1) : 8'(8'h2B + i));
      `CHK("mode", 1'b0, mode)
    end
    emu <= 1'b1;
    pre <= 1'b0;
    sec <= 1'b0;
    key <= `FP_UNLOCK_KEY;
  endtask

  task automatic t_erase();
    int e, c, s, k;
    e = n_er;
    c = n_cr;
    s = n_sc;
    enter(`FP_SEL_ERASE);
    `CHK("entry", 3'b111, {mode, halt, cdis})
    `CHK("ctrl reset", c + 1, n_cr)
    `CHK("erase", e + 1, n_er)
    poll();
    `CHK("busy status", 2'b10, st[1:0])
    k = 0;
    do begin
      poll();
      k++;
    end while (st[0] !== 1'b1 && k < 20);
    stop_if(k >= 20);
    `CHK("secure clear", s + 1, n_sc)
    tpin <= 1'b0;
    poll();
    `CHK("test off", 2'b01, st[1:0])
    tpin <= 1'b1;
  endtask

  task automatic t_write();
    int w;
    w = n_wr;
    frame(`FP_CMD_WRITE, 16'h0010, 3'h2, 32'h55AA);
    `CHK("word", {16'h0010, 16'h55AA}, {w_addr, w_data})
    for (int j = 0; j < 2; j++) begin
      frame(j ? 8'h01 : 8'h00, j ? 16'h0010 : 16'h0013, 3'h2, 32'h1234);
      poll();
      `CHK("not ready", 1'b1, st[7])
      `CHK("word count", w + 1, n_wr)
    end
  endtask

  task automatic t_read();
    frame(`FP_CMD_READ, 16'h0020, 3'h2, 32'h0);
    `CHK("flash bytes", 16'h1D1C, rx[15:0])
    frame(8'h81, 16'h0020, 3'h1, 32'h0);
    `CHK("bad read", 8'h00, rx[7:0])
  endtask

  task automatic t_reset();
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    `CHK("after reset", 3'b000, {mode, halt, cdis})
    frame(`FP_CMD_READ, `FP_MODE_SELECT_ADDR, 3'h1, 32'h0);
    `CHK("select", 8'h00, rx[7:0])
  endtask

  task automatic t_readback();
    int w, e;
    w = n_wr;
    e = n_er;
    enter(`FP_SEL_READBACK);
    `CHK("mode", 1'b1, mode)
    frame(`FP_CMD_WRITE, 16'h0010, 3'h2, 32'h55AA);
    `CHK("blocked", {w, e}, {n_wr, n_er})
  endtask

  // main sequence
  initial begin
    resetn_i = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    emu = 1'b1;
    pre = 1'b0;
    sec = 1'b0;
    key = `FP_UNLOCK_KEY;
    tpin = 1'b1;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_select();
    t_guard();
    t_erase();
    t_write();
    t_read();
    t_reset();
    t_readback();
    conclude();
  end
endmodule

// >>> rtl/flash_prog_defs.svh
`ifndef FLASH_PROG_DEFS_SVH
`define FLASH_PROG_DEFS_SVH

// device registers reached over the serial link
`define FP_MODE_SELECT_ADDR 16'h2080
`define FP_MODE_TRIGGER_ADDR 16'h2081
`define FP_MODE_SELECT_RST 8'h00

// mode select codes, trigger key and unlock key
`define FP_SEL_ERASE 8'hD1
`define FP_SEL_READBACK 8'h2E
`define FP_TRIGGER_KEY 8'h96
`define FP_UNLOCK_KEY 4'h2

// command bytes accepted inside the programming mode
`define FP_CMD_WRITE 8'h00
`define FP_CMD_READ 8'h80

// byte positions within a frame, counted from zero
`define FP_BYTE_CMD 4'h0
`define FP_BYTE_ADDR_HI 4'h1
`define FP_BYTE_ADDR_LO 4'h2
`define FP_BYTE_STATUS 4'h3
`define FP_BYTE_DATA0 4'h4
`define FP_BYTE_DATA1 4'h5
`define FP_BYTE_MAX 4'hF

// status byte fields
`define FP_ST_NOT_READY 7
`define FP_ST_RD_PARITY 6
`define FP_ST_WR_PARITY 5
`define FP_ST_COUNT_LSB 2
`define FP_ST_MODE 1
`define FP_ST_READY 0
`define FP_ST_COUNT_SHORT 3'h7

// link timing: half period of the clock the host makes
`define FP_CLK_PERIOD_NS 100
`define FP_LINK_HALF_NS 800
`define FP_LINK_HALF_CYC (`FP_LINK_HALF_NS / `FP_CLK_PERIOD_NS)

// host register map on the system bus
`define FP_HOST_CTRL 8'h00
`define FP_HOST_ADDR 8'h04
`define FP_HOST_TXDATA 8'h08
`define FP_HOST_RXDATA 8'h0C
`define FP_HOST_LINKSTAT 8'h10
`define FP_CTRL_START 31
`define FP_CTRL_COUNT_LSB 8
`define FP_HOST_MAX_DATA 3'h4

`endif

// >>> rtl/flash_prog_device.sv
`timescale 1ns/10ps
`include "flash_prog_defs.svh"

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - flash reachable over link only in mode
// - word writes, even start, commit odd byte
// - processor halted, no completion interrupt
// - entry needs emulator, flags clear, unlock key
// - secure set: erase only, no read-back (here unlock_ok refuses every entry, erase included)
// - select and trigger writable only via link
// - select 0xD1 arms erase on entry
// - select 0x2E arms read-back, writes blocked
// - other select values never enter mode
// - trigger 0x96 enters, other values ignored
// - every trigger write clears select value
// - entry disables engine and halts processor
// - entry resets flash control logic
// - erase completion clears secure bit
// - in mode all addresses map onto flash
// - four byte frame returns operation status
// - writes six bytes, command 0x00, no increment
// - reads use 0x80, auto-increment allowed
// - frame lasts while select is low
// - status bit0 ready, bit1 mode with test
// - status bit7 reports previous not ready
module flash_prog_device (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // serial link
  flash_prog_if.device link,
  // entry preconditions and test pin
  input wire logic emulator_enable_input_i,
  input wire logic phase_flag_a_i,
  input wire logic secure_i,
  input wire logic [3:0] flash_unlock_key_i,
  input wire logic test_pin_i,
  // shared access address
  output logic [15:0] access_addr_o,
  // data memory port
  input wire logic [7:0] mem_rdata_i,
  output logic mem_we_o,
  output logic [7:0] mem_wdata_o,
  // flash port
  input wire logic [7:0] flash_rdata_i,
  input wire logic flash_busy_i,
  output logic flash_write_o,
  output logic [15:0] flash_wdata_o,
  output logic flash_erase_o,
  output logic flash_ctrl_reset_o,
  output logic secure_clear_o,
  // system control
  output logic flash_program_mode_o,
  output logic processor_halt_o,
  output logic compute_disable_o
);

  logic sclk_s1, sclk_s2, sclk_d;
  logic sel_s1, sel_s2, sel_d;
  logic mosi_s1, mosi_s2;
  logic [2:0] bit_cnt;
  logic [3:0] byte_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic [7:0] cmd;
  logic [7:0] addr_hi;
  logic [7:0] word_low;
  logic [7:0] mode_select;
  logic readback_mode;
  logic erase_wait, erase_run;
  logic err, rd_par, wr_par;
  logic [7:2] status_prev;

  ////////////////////////////////////////////////////////////////////////
  // link synchronisers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d <= 1'b0;
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_d <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      sel_s1 <= link.serial_select_n;
      sel_s2 <= sel_s1;
      sel_d <= sel_s2;
      mosi_s1 <= link.mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  // edges and frame events
  wire rise = sclk_s2 & ~sclk_d & ~sel_s2;
  wire fall = ~sclk_s2 & sclk_d & ~sel_s2;
  wire frame_start = ~sel_s2 & sel_d;
  wire frame_end = sel_s2 & ~sel_d;
  wire byte_done = rise & (bit_cnt == 3'h7);
  wire [7:0] rx_byte = {rx_sh[6:0], mosi_s2};
  wire is_read = cmd[7];

  // entry checks and access permissions
  wire unlock_ok = emulator_enable_input_i & ~phase_flag_a_i & ~secure_i &
    (flash_unlock_key_i == `FP_UNLOCK_KEY);
  wire sel_ok = (mode_select == `FP_SEL_ERASE) |
    ((mode_select == `FP_SEL_READBACK) & ~secure_i);
  wire read_ok = ~secure_i & (cmd == `FP_CMD_READ) & ~flash_busy_i;
  wire write_ok = ~secure_i & ~readback_mode & (cmd == `FP_CMD_WRITE) &
    ~access_addr_o[0];

  // byte strobes
  wire load_rd = byte_done & is_read & (byte_cnt >= `FP_BYTE_STATUS);
  wire wr_byte = byte_done & ~is_read & (byte_cnt >= `FP_BYTE_DATA0);
  wire norm_wr = wr_byte & ~flash_program_mode_o;
  wire sel_wr = norm_wr & (access_addr_o == `FP_MODE_SELECT_ADDR);
  wire trig_wr = norm_wr & (access_addr_o == `FP_MODE_TRIGGER_ADDR);
  wire mem_wr = norm_wr & ~sel_wr & ~trig_wr;
  wire enter = trig_wr & (rx_byte == `FP_TRIGGER_KEY) & sel_ok &
    unlock_ok;

  // read byte source: flash in mode, memory or select register outside
  wire [7:0] rd_byte = flash_program_mode_o ?
    (read_ok ? flash_rdata_i : 8'h00) :
    (access_addr_o == `FP_MODE_SELECT_ADDR) ? mode_select :
    (access_addr_o == `FP_MODE_TRIGGER_ADDR) ? 8'h00 : mem_rdata_i;

  // live status byte
  logic [7:0] status_now;
  always_comb begin
    status_now = {status_prev, 2'b00};
    status_now[`FP_ST_MODE] = flash_program_mode_o & test_pin_i;
    status_now[`FP_ST_READY] = flash_program_mode_o & ~flash_busy_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // receive shifter, byte counter, command and address capture
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 4'h0;
      rx_sh <= 8'h00;
      cmd <= 8'h00;
      addr_hi <= 8'h00;
    end else if (frame_start) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 4'h0;
    end else if (rise) begin
      rx_sh <= rx_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        if (byte_cnt != `FP_BYTE_MAX) begin
          byte_cnt <= byte_cnt + 4'h1;
        end
        if (byte_cnt == `FP_BYTE_CMD) begin
          cmd <= rx_byte;
        end
        if (byte_cnt == `FP_BYTE_ADDR_HI) begin
          addr_hi <= rx_byte;
        end
      end
    end
  end

  // transmit shifter: status then read data, changed on falling edges
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_sh <= 8'h00;
      link.miso <= 1'b0;
    end else if (frame_start) begin
      tx_sh <= 8'h00;
      link.miso <= 1'b0;
    end else if (byte_done & (byte_cnt == `FP_BYTE_ADDR_LO)) begin
      tx_sh <= status_now;
      link.miso <= status_now[7];
    end else if (load_rd) begin
      tx_sh <= rd_byte;
      link.miso <= rd_byte[7];
    end else if (byte_done) begin
      tx_sh <= 8'h00;
      link.miso <= 1'b0;
    end else if (fall & (bit_cnt != 3'h0)) begin
      tx_sh <= {tx_sh[6:0], 1'b0};
      link.miso <= tx_sh[6];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access pointer and write strobes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      access_addr_o <= 16'h0000;
      mem_we_o <= 1'b0;
      mem_wdata_o <= 8'h00;
      flash_write_o <= 1'b0;
      flash_wdata_o <= 16'h0000;
      word_low <= 8'h00;
    end else begin
      mem_we_o <= 1'b0;
      flash_write_o <= 1'b0;
      if (byte_done & (byte_cnt == `FP_BYTE_ADDR_LO)) begin
        access_addr_o <= {addr_hi, rx_byte};
      end else if (load_rd) begin
        // step past the byte just loaded so the next load is fresh
        access_addr_o <= access_addr_o + 16'h0001;
      end else if (mem_we_o) begin
        access_addr_o <= access_addr_o + 16'h0001;
      end
      if (mem_wr) begin
        mem_we_o <= 1'b1;
        mem_wdata_o <= rx_byte;
      end
      if (wr_byte & flash_program_mode_o) begin
        if (byte_cnt == `FP_BYTE_DATA0) begin
          word_low <= rx_byte;
        end
        if ((byte_cnt == `FP_BYTE_DATA1) & write_ok & ~flash_busy_i) begin
          flash_write_o <= 1'b1;
          flash_wdata_o <= {rx_byte, word_low};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode select register and mode entry
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_select <= `FP_MODE_SELECT_RST;
      flash_program_mode_o <= 1'b0;
      processor_halt_o <= 1'b0;
      compute_disable_o <= 1'b0;
      readback_mode <= 1'b0;
      flash_ctrl_reset_o <= 1'b0;
      flash_erase_o <= 1'b0;
    end else begin
      flash_ctrl_reset_o <= 1'b0;
      flash_erase_o <= 1'b0;
      if (sel_wr) begin
        mode_select <= rx_byte;
      end
      if (trig_wr) begin
        mode_select <= `FP_MODE_SELECT_RST;
      end
      if (enter) begin
        flash_program_mode_o <= 1'b1;
        processor_halt_o <= 1'b1;
        compute_disable_o <= 1'b1;
        readback_mode <= (mode_select == `FP_SEL_READBACK);
        flash_ctrl_reset_o <= 1'b1;
        flash_erase_o <= (mode_select == `FP_SEL_ERASE);
      end
    end
  end

  // mass erase tracking: clear secure when busy drops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      erase_wait <= 1'b0;
      erase_run <= 1'b0;
      secure_clear_o <= 1'b0;
    end else begin
      secure_clear_o <= 1'b0;
      if (flash_erase_o) begin
        erase_wait <= 1'b1;
      end else if (erase_wait & flash_busy_i) begin
        erase_wait <= 1'b0;
        erase_run <= 1'b1;
      end else if (erase_run & ~flash_busy_i) begin
        erase_run <= 1'b0;
        secure_clear_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-frame error and parity, latched into status at frame end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      err <= 1'b0;
      rd_par <= 1'b0;
      wr_par <= 1'b0;
      status_prev <= 6'h3F;
    end else if (frame_start) begin
      err <= 1'b0;
      rd_par <= 1'b0;
      wr_par <= 1'b0;
    end else if (frame_end) begin
      status_prev[`FP_ST_NOT_READY] <= err;
      status_prev[`FP_ST_RD_PARITY] <= rd_par;
      status_prev[`FP_ST_WR_PARITY] <= wr_par;
      status_prev[4:`FP_ST_COUNT_LSB] <= (byte_cnt >= `FP_BYTE_DATA0) ?
        3'(byte_cnt - `FP_BYTE_STATUS) : `FP_ST_COUNT_SHORT;
    end else if (byte_done) begin
      wr_par <= wr_par ^ (^rx_byte);
      if (load_rd & (byte_cnt != `FP_BYTE_MAX)) begin
        rd_par <= rd_par ^ (^rd_byte);
      end
      if (flash_program_mode_o & load_rd & ~read_ok) begin
        err <= 1'b1;
      end
      if (flash_program_mode_o & wr_byte & (~write_ok |
          (byte_cnt > `FP_BYTE_DATA1) |
          ((byte_cnt == `FP_BYTE_DATA1) & flash_busy_i))) begin
        err <= 1'b1;
      end
    end
  end

endmodule

// >>> rtl/flash_prog_host.sv
`timescale 1ns/10ps
`include "flash_prog_defs.svh"

module flash_prog_host #(
  parameter int HALF = `FP_LINK_HALF_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // system bus slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // serial link
  flash_prog_if.host link
);

  flash_prog_pkg::link_state_t state;
  logic ap_valid, ap_write;
  logic [7:0] ap_addr;
  logic [7:0] cmd_reg;
  logic [2:0] count_reg;
  logic [15:0] addr_reg;
  logic [31:0] txdata;
  logic [31:0] rxdata;
  logic [7:0] status_byte;
  logic busy;
  logic miso_s1, miso_s2;
  logic [7:0] div;
  logic [2:0] bit_i;
  logic [3:0] byte_i;
  logic [7:0] tx_sh, rx_sh;

  wire half_done = (div == 8'(HALF - 1));
  wire bus_wr = ap_valid & ap_write;
  wire start = bus_wr & (ap_addr == `FP_HOST_CTRL) &
    hwdata[`FP_CTRL_START] & ~busy;
  wire [2:0] req_count = hwdata[`FP_CTRL_COUNT_LSB +: 3];
  wire [3:0] last_byte = `FP_BYTE_STATUS + {1'b0, count_reg};

  // outgoing byte for a frame position
  function automatic logic [7:0] frame_byte(input logic [3:0] k);
    logic [7:0] b;
    b = 8'h00;
    if (k == `FP_BYTE_CMD) b = cmd_reg;
    else if (k == `FP_BYTE_ADDR_HI) b = addr_reg[15:8];
    else if (k == `FP_BYTE_ADDR_LO) b = addr_reg[7:0];
    else if (k >= `FP_BYTE_DATA0) b = txdata[{k[1:0], 3'h0} +: 8];
    return b;
  endfunction

  // byte that follows the current one in the frame
  wire [7:0] next_tx = frame_byte(byte_i + 4'h1);

  ////////////////////////////////////////////////////////////////////////
  // bus address phase capture
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
    end else begin
      ap_valid <= hsel & htrans[1] & hready;
      if (hready) begin
        ap_write <= hwrite;
        ap_addr <= haddr[7:0];
      end
    end
  end

  // reads take one wait state so data reflect finished writes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      hreadyout <= ~(hsel & htrans[1] & hready & ~hwrite);
      if (ap_valid & ~ap_write) begin
        case (ap_addr)
          `FP_HOST_CTRL: hrdata <= {busy, 20'h00000, count_reg, cmd_reg};
          `FP_HOST_ADDR: hrdata <= {16'h0000, addr_reg};
          `FP_HOST_TXDATA: hrdata <= txdata;
          `FP_HOST_RXDATA: hrdata <= rxdata;
          `FP_HOST_LINKSTAT: hrdata <= {23'h000000, busy, status_byte};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // frame setup registers, frozen while a frame runs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_reg <= 8'h00;
      count_reg <= 3'h0;
      addr_reg <= 16'h0000;
      txdata <= 32'h00000000;
    end else if (bus_wr & ~busy) begin
      if (ap_addr == `FP_HOST_CTRL) begin
        cmd_reg <= hwdata[7:0];
        count_reg <= (req_count > `FP_HOST_MAX_DATA) ?
          `FP_HOST_MAX_DATA : req_count;
      end
      if (ap_addr == `FP_HOST_ADDR) begin
        addr_reg <= hwdata[15:0];
      end
      if (ap_addr == `FP_HOST_TXDATA) begin
        txdata <= hwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // returning data synchroniser
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      miso_s1 <= link.miso;
      miso_s2 <= miso_s1;
    end
  end

  // link sequencer: select, divided clock, msb first, mode 0
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= flash_prog_pkg::LINK_IDLE;
      link.sclk <= 1'b0;
      link.serial_select_n <= 1'b1;
      link.mosi <= 1'b0;
      busy <= 1'b0;
      div <= 8'h00;
      bit_i <= 3'h0;
      byte_i <= 4'h0;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      rxdata <= 32'h00000000;
      status_byte <= 8'h00;
    end else begin
      div <= half_done ? 8'h00 : div + 8'h01;
      unique case (state)
        flash_prog_pkg::LINK_IDLE: begin
          div <= 8'h00;
          if (start) begin
            busy <= 1'b1;
            link.serial_select_n <= 1'b0;
            // cmd_reg loads on this same edge, so take the bus word
            tx_sh <= hwdata[7:0];
            link.mosi <= hwdata[7];
            bit_i <= 3'h0;
            byte_i <= 4'h0;
            state <= flash_prog_pkg::LINK_SETUP;
          end
        end
        flash_prog_pkg::LINK_SETUP, flash_prog_pkg::LINK_LOW: begin
          if (half_done) begin
            link.sclk <= 1'b1;
            rx_sh <= {rx_sh[6:0], miso_s2};
            state <= flash_prog_pkg::LINK_HIGH;
          end
        end
        flash_prog_pkg::LINK_HIGH: begin
          if (half_done) begin
            link.sclk <= 1'b0;
            state <= flash_prog_pkg::LINK_LOW;
            if (bit_i == 3'h7) begin
              if (byte_i == `FP_BYTE_STATUS) begin
                status_byte <= rx_sh;
              end
              if (byte_i >= `FP_BYTE_DATA0) begin
                rxdata[{byte_i[1:0], 3'h0} +: 8] <= rx_sh;
              end
              bit_i <= 3'h0;
              if (byte_i == last_byte) begin
                link.mosi <= 1'b0;
                state <= flash_prog_pkg::LINK_TAIL;
              end else begin
                byte_i <= byte_i + 4'h1;
                tx_sh <= next_tx;
                link.mosi <= next_tx[7];
              end
            end else begin
              bit_i <= bit_i + 3'h1;
              tx_sh <= {tx_sh[6:0], 1'b0};
              link.mosi <= tx_sh[6];
            end
          end
        end
        flash_prog_pkg::LINK_TAIL: begin
          if (half_done) begin
            link.serial_select_n <= 1'b1;
            state <= flash_prog_pkg::LINK_GAP;
          end
        end
        flash_prog_pkg::LINK_GAP: begin
          if (half_done) begin
            busy <= 1'b0;
            state <= flash_prog_pkg::LINK_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// >>> rtl/flash_prog_if.sv
`timescale 1ns/10ps

interface flash_prog_if;
  logic sclk;
  logic serial_select_n;
  logic mosi;
  logic miso;

  // device end: the documented part
  modport device (
    input sclk,
    input serial_select_n,
    input mosi,
    output miso
  );

  // host end: the programmer that makes the link clock
  modport host (
    output sclk,
    output serial_select_n,
    output mosi,
    input miso
  );
endinterface

// >>> rtl/flash_prog_pkg.sv
package flash_prog_pkg;

  // host link sequencer states, gray along the bit loop
  typedef enum logic [2:0] {
    LINK_IDLE = 3'h0,
    LINK_SETUP = 3'h1,
    LINK_HIGH = 3'h3,
    LINK_LOW = 3'h2,
    LINK_TAIL = 3'h6,
    LINK_GAP = 3'h4
  } link_state_t;

endpackage
